// ### scftp_defines.vh
// constants for the serial configuration and test pattern block
`ifndef SCFTP_DEFINES_VH
`define SCFTP_DEFINES_VH
// ==========================================================
// serial frame layout
`define SCFTP_FRAME_BITS     5'h10
`define SCFTP_DIR_BIT        15
`define SCFTP_ADDR_HI        13
`define SCFTP_ADDR_LO        8
`define SCFTP_DATA_HI        7
`define SCFTP_DATA_LO        0
`define SCFTP_DATA_START     5'h08
// ==========================================================
// register offsets
`define SCFTP_ADDR_SYNC      6'h01
`define SCFTP_ADDR_SEQ01     6'h08
`define SCFTP_ADDR_SEQ67     6'h0b
`define SCFTP_ADDR_USER6_HI  6'h0c
`define SCFTP_ADDR_USER6_LO  6'h0d
`define SCFTP_ADDR_USER7_HI  6'h0e
`define SCFTP_ADDR_USER7_LO  6'h0f
`define SCFTP_ADDR_PAT_CTRL  6'h10
// ==========================================================
// fields and reset values
`define SCFTP_SYNC_PHASE_BIT 7
`define SCFTP_SYNC_DIV_BIT   6
`define SCFTP_SYNC_RESET     8'h10
`define SCFTP_SEQ_RESET      8'h48
`define SCFTP_SEQ_CODE_RESET 3'h2
`define SCFTP_PAT_EN_BIT     0
`define SCFTP_PAT_CTRL_RESET 8'h00
`endif

// ### scftp_clock_gen.v
// internal clock divide and phase inversion for the sampling edge
`include "scftp_defines.vh"

module scftp_clock_gen (
  input  wire mclk,
  input  wire rst,
  input  wire div_by_two,
  input  wire invert_phase,
  output reg  int_clk,
  output reg  sample_strobe
);
  reg div_toggle;
  reg raw_clk;
  reg prev_clk;
  wire next_raw;

  // ==========================================================
  // divider: mclk edges stand in for input_sample_clock edges
  // inversion sits after the divider so the /1 clock never freezes
  assign next_raw = div_by_two ? (div_toggle ? ~raw_clk : raw_clk) : ~raw_clk;

  always @(posedge mclk) begin
    if (rst) begin
      div_toggle    <= 1'b0;
      raw_clk       <= 1'b0;
      int_clk       <= 1'b0;
      prev_clk      <= 1'b0;
      sample_strobe <= 1'b0;
    end else begin
      div_toggle    <= ~div_toggle;
      raw_clk       <= next_raw;
      int_clk       <= next_raw ^ invert_phase;
      prev_clk      <= int_clk;
      // sample on falling edge of the internal clock
      sample_strobe <= prev_clk & ~int_clk;
    end
  end
endmodule // scftp_clock_gen

// ### scftp_pattern_gen.v
// fixed pattern lookup for one 3-bit code
`include "scftp_defines.vh"

module scftp_pattern_gen (
  input  wire [2:0]  code,
  input  wire [15:0] user6,
  input  wire [15:0] user7,
  output reg  [15:0] pattern
);
  // ==========================================================
  // hard-wired table, user codes last
  always @* begin
    case (code)
      3'h0: pattern = 16'h0000;
      3'h1: pattern = 16'hffff;
      3'h2: pattern = 16'haaaa;
      3'h3: pattern = 16'h8000;
      3'h4: pattern = 16'hff00;
      3'h5: pattern = 16'h00ff;
      3'h6: pattern = user6;
      3'h7: pattern = user7;
      default: pattern = 16'h0000;
    endcase
  end
endmodule // scftp_pattern_gen

// ### scftp_top.v
// serial control port, register file and fixed pattern output
`include "scftp_defines.vh"

module scftp_top (
  input  wire        mclk,
  input  wire        rst,
  input  wire        serial_clk,
  input  wire        select_n,
  input  wire        serial_in,
  output reg         serial_out,
  output reg         serial_out_en,
  input  wire [15:0] conv_data,
  output reg  [7:0]  ddr_data,
  output reg         output_strobe,
  output reg         int_clk_out,
  output reg         sample_strobe_out,
  output reg  [5:0]  last_addr
);
  // ==========================================================
  // register storage, indexed by address
  reg  [7:0]  regs [0:63];
  reg         sclk_d;
  reg         csn_d;
  reg  [4:0]  bit_cnt;
  reg  [15:0] shift_in;
  reg  [7:0]  shift_out;
  reg  [2:0]  slot;
  reg         half;
  reg  [15:0] cur_word;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_start;
  wire        cs_end;
  wire        frame_full;
  wire        is_read;
  wire [5:0]  rd_addr;
  wire [2:0]  slot_code;
  wire [15:0] slot_pattern;
  wire        int_clk;
  wire        sample_strobe;
  wire        pat_en;
  wire [7:0]  sync_reg;
  integer     i;

  // slot n lives in register 08h + n/2, even slot at bits 4:2, odd at 7:5
  function [2:0] slot_field;
    input [2:0] idx;
    input [7:0] val;
    begin
      slot_field = idx[0] ? val[7:5] : val[4:2];
    end
  endfunction

  // reset value of each address
  function [7:0] reset_value;
    input [5:0] a;
    begin
      if (a == `SCFTP_ADDR_SYNC)
        reset_value = `SCFTP_SYNC_RESET;
      else if (a >= `SCFTP_ADDR_SEQ01 && a <= `SCFTP_ADDR_SEQ67)
        reset_value = `SCFTP_SEQ_RESET;
      else
        reset_value = 8'h00;
    end
  endfunction

  // ==========================================================
  // serial edge detection, inputs synchronous to mclk
  assign sclk_rise  = serial_clk & ~sclk_d;
  assign sclk_fall  = ~serial_clk & sclk_d;
  assign cs_start   = ~select_n & csn_d;
  assign cs_end     = select_n & ~csn_d;
  assign frame_full = (bit_cnt == `SCFTP_FRAME_BITS);
  assign is_read    = shift_in[`SCFTP_DIR_BIT];
  assign rd_addr    = shift_in[`SCFTP_ADDR_HI-8:0];

  always @(posedge mclk) begin
    if (rst) begin
      sclk_d <= 1'b0;
      csn_d  <= 1'b1;
    end else begin
      sclk_d <= serial_clk;
      csn_d  <= select_n;
    end
  end

  // ==========================================================
  // frame shifter: count rising edges while selected
  // a count capped at 16 keeps extra clocks from wrapping into a
  // second access, so no burst is possible
  always @(posedge mclk) begin
    if (rst) begin
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
    end else if (cs_start) begin
      bit_cnt  <= 5'h00;
      shift_in <= 16'h0000;
    end else if (!select_n && sclk_rise && !frame_full) begin
      shift_in <= {shift_in[14:0], serial_in};
      bit_cnt  <= bit_cnt + 5'h01;
    end
  end

  // ==========================================================
  // read data: load at the address boundary, shift on falling edges
  always @(posedge mclk) begin
    if (rst) begin
      shift_out     <= 8'h00;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end else if (select_n) begin
      serial_out_en <= 1'b0;
      serial_out    <= 1'b0;
    end else if (sclk_fall && bit_cnt == `SCFTP_DATA_START &&
                 shift_in[`SCFTP_DIR_BIT-8]) begin
      // address complete: first data bit is the msb
      serial_out_en <= 1'b1;
      serial_out    <= regs[rd_addr][7];
      shift_out     <= {regs[rd_addr][6:0], 1'b0};
    end else if (sclk_fall && serial_out_en && !frame_full) begin
      serial_out <= shift_out[7];
      shift_out  <= {shift_out[6:0], 1'b0};
    end else if (sclk_fall && frame_full) begin
      serial_out_en <= 1'b0;
    end
  end

  // ==========================================================
  // commit on select release; only whole frames count
  always @(posedge mclk) begin
    if (rst) begin
      for (i = 0; i < 64; i = i + 1)
        regs[i] <= reset_value(i[5:0]);
      last_addr <= 6'h00;
    end else if (cs_end && frame_full) begin
      last_addr <= shift_in[`SCFTP_ADDR_HI:`SCFTP_ADDR_LO];
      if (!is_read)
        regs[shift_in[`SCFTP_ADDR_HI:`SCFTP_ADDR_LO]] <=
          shift_in[`SCFTP_DATA_HI:`SCFTP_DATA_LO];
    end
  end

  // ==========================================================
  // clocking options from the synchronization register, pattern enable from register 10h
  assign sync_reg = regs[`SCFTP_ADDR_SYNC];
  assign pat_en   = regs[`SCFTP_ADDR_PAT_CTRL][`SCFTP_PAT_EN_BIT];

  scftp_clock_gen u_clk (
    .mclk          (mclk),
    .rst           (rst),
    .div_by_two    (sync_reg[`SCFTP_SYNC_DIV_BIT]),
    .invert_phase  (sync_reg[`SCFTP_SYNC_PHASE_BIT]),
    .int_clk       (int_clk),
    .sample_strobe (sample_strobe)
  );

  // ==========================================================
  // pattern sequencer
  assign slot_code = slot_field(slot, regs[`SCFTP_ADDR_SEQ01 + {4'h0, slot[2:1]}]);

  scftp_pattern_gen u_pat (
    .code    (slot_code),
    .user6   ({regs[`SCFTP_ADDR_USER6_HI], regs[`SCFTP_ADDR_USER6_LO]}),
    .user7   ({regs[`SCFTP_ADDR_USER7_HI], regs[`SCFTP_ADDR_USER7_LO]}),
    .pattern (slot_pattern)
  );

  // one word per two mclk cycles: rising half carries even bits,
  // falling half odd bits; strobe high marks the rising half
  always @(posedge mclk) begin
    if (rst) begin
      slot              <= 3'h0;
      half              <= 1'b0;
      cur_word          <= 16'h0000;
      ddr_data          <= 8'h00;
      output_strobe     <= 1'b0;
      int_clk_out       <= 1'b0;
      sample_strobe_out <= 1'b0;
    end else begin
      int_clk_out       <= int_clk;
      sample_strobe_out <= sample_strobe;
      half              <= ~half;
      if (!half) begin
        // fetch next word and present even bits with the rising edge
        cur_word      <= pat_en ? slot_pattern : conv_data;
        ddr_data      <= pat_en ?
          {slot_pattern[14], slot_pattern[12], slot_pattern[10], slot_pattern[8],
           slot_pattern[6], slot_pattern[4], slot_pattern[2], slot_pattern[0]} :
          {conv_data[14], conv_data[12], conv_data[10], conv_data[8],
           conv_data[6], conv_data[4], conv_data[2], conv_data[0]};
        output_strobe <= 1'b1;
        slot          <= pat_en ? slot + 3'h1 : 3'h0;
      end else begin
        ddr_data      <= {cur_word[15], cur_word[13], cur_word[11], cur_word[9],
                          cur_word[7], cur_word[5], cur_word[3], cur_word[1]};
        output_strobe <= 1'b0;
      end
    end
  end
endmodule // scftp_top

// ### scftp_master.sv
// controller model driving the serial configuration port
module scftp_master (
  input  wire  mclk,
  input  wire  serial_out,
  input  wire  serial_out_en,
  output logic serial_clk,
  output logic select_n,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock parked low and select idle outside frames
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  // ==========
  // one frame of n bits, msb first; n below 16 makes a short frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge mclk) select_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      // released during read data, so the line keeps moving
      @(posedge mclk) serial_in <= (w[15] && i < 8) ? ~serial_in : w[i];
      repeat (2) @(posedge mclk);
      serial_clk <= 1'b1;
      if (i < 8) rd[i] = serial_out;
      repeat (2) @(posedge mclk);
      serial_clk <= 1'b0;
    end
    @(posedge mclk) select_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
endmodule // scftp_master

// ### scftp_monitor.sv
// port assertions for the serial configuration block
module scftp_monitor (
  input wire       mclk,
  input wire       rst,
  input wire       serial_clk,
  input wire       select_n,
  input wire       serial_out,
  input wire       serial_out_en,
  input wire       output_strobe,
  input wire       int_clk_out,
  input wire       sample_strobe_out,
  input wire [5:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========
  // serial port
  a_out_on_low: assert property ($changed(serial_out) |-> !serial_clk)
    else $error("read data moved with serial clock high");
  a_en_clk_low: assert property ($rose(serial_out_en) |-> !serial_clk && !select_n)
    else $error("read enable rose at a bad time");
  a_en_idle_off: assert property (select_n [*3] |-> !serial_out_en)
    else $error("read enable high while deselected");
  a_en_no_bounce: assert property ($fell(serial_out_en) |=> !serial_out_en)
    else $error("read enable bounced");
  a_addr_on_release: assert property ($changed(last_addr) |-> $past(select_n))
    else $error("address latched inside a frame");
  // ==========
  // clocks and output port
  a_strobe_toggles: assert property (!$past(rst) |-> output_strobe != $past(output_strobe))
    else $error("output strobe missed a toggle");
  a_sample_one: assert property (sample_strobe_out |=> !sample_strobe_out)
    else $error("sample pulse longer than one cycle");
  a_int_clk_moves: assert property (!$past(rst) && $stable(int_clk_out) |=> $changed(int_clk_out))
    else $error("internal clock held too long");
  c_read: cover property ($rose(serial_out_en));
  c_commit: cover property ($changed(last_addr));
  c_sample: cover property ($rose(sample_strobe_out));
endmodule // scftp_monitor
bind scftp_top scftp_monitor mon (.mclk(mclk), .rst(rst), .serial_clk(serial_clk),
  .select_n(select_n), .serial_out(serial_out), .serial_out_en(serial_out_en),
  .output_strobe(output_strobe), .int_clk_out(int_clk_out),
  .sample_strobe_out(sample_strobe_out), .last_addr(last_addr));

// ### scftp_top_tb.sv
// bench for the serial configuration and test pattern block
module scftp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] conv_data = 16'h0000;
  logic        serial_clk, select_n, drv, serial_out, serial_out_en;
  logic        output_strobe, int_clk_out, sample_strobe_out;
  logic [7:0]  ddr_data, rd;
  logic [5:0]  last_addr;
  logic [15:0] w;
  int          n_fail = 0, comparisons = 0, cyc = 0, c0 = 0;
  // word per pattern code, user codes as programmed below
  logic [15:0] pat [8] = '{16'h0000, 16'hffff, 16'haaaa, 16'h8000,
                           16'hff00, 16'h00ff, 16'h1234, 16'h5678};
  // slots hold codes 0..7, then user bytes, at 08h..0fh
  logic [7:0]  rv [8] = '{8'h20, 8'h68, 8'hb0, 8'hf8, 8'h12, 8'h34, 8'h56, 8'h78};
  // shared data wire: the device owns it only while enabled
  wire         serial_in = serial_out_en ? serial_out : drv;
  always #50 mclk = ~mclk;
  scftp_master m (.mclk(mclk), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .serial_clk(serial_clk), .select_n(select_n), .serial_in(drv));
  scftp_top uut (.mclk(mclk), .rst(rst), .serial_clk(serial_clk), .select_n(select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .conv_data(conv_data), .ddr_data(ddr_data), .output_strobe(output_strobe),
    .int_clk_out(int_clk_out), .sample_strobe_out(sample_strobe_out),
    .last_addr(last_addr));
  // ==========
  // checking and bus tasks
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    m.xfer({2'b00, a, d}, 16, rd);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    m.xfer({2'b10, a, 8'h00}, 16, rd);
    chk("read data", 16'(e), 16'(rd));
    chk("last address", 16'(a), 16'(last_addr));
  endtask
  // even half comes with the strobe high, odd half next cycle
  task automatic getw(output logic [15:0] g);
    @(posedge mclk iff output_strobe === 1'b1);
    for (int i = 0; i < 8; i++) g[2*i] = ddr_data[i];
    @(posedge mclk);
    for (int i = 0; i < 8; i++) g[2*i+1] = ddr_data[i];
  endtask
  // count clock toggles and sample pulses over 16 cycles
  task automatic clkchk(input int t, input int p);
    int   nt = 0;
    int   np = 0;
    logic prev;
    repeat (4) @(posedge mclk);
    prev = int_clk_out;
    repeat (16) begin
      @(posedge mclk);
      nt += int'(int_clk_out !== prev);
      np += int'(sample_strobe_out === 1'b1);
      prev = int_clk_out;
    end
    chk("clock toggles", 16'(t), 16'(nt));
    chk("sample pulses", 16'(p), 16'(np));
  endtask
  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    conv_data <= 16'h3c5a;
    clkchk(16, 8);
    rdchk(6'h01, 8'h10);
    for (int a = 8; a < 17; a++) rdchk(6'(a), a < 12 ? 8'h48 : 8'h00);
    getw(w);
    chk("converter word", 16'h3c5a, w);
    wr(6'h10, 8'h01);
    repeat (4) @(posedge mclk);
    getw(w);
    chk("default pattern", 16'haaaa, w);
    wr(6'h10, 8'h00);
    for (int a = 0; a < 8; a++) wr(6'(a + 8), rv[a]);
    for (int a = 0; a < 8; a++) rdchk(6'(a + 8), rv[a]);
    m.xfer(16'h0cff, 12, rd);
    chk("last address", 16'h000f, 16'(last_addr));
    rdchk(6'h0c, 8'h12);
    wr(6'h10, 8'h01);
    repeat (4) @(posedge mclk);
    getw(w);
    for (int c = 0; c < 8; c++) if (w === pat[c]) c0 = c;
    for (int k = 1; k < 11; k++) begin
      getw(w);
      chk("pattern word", pat[(c0 + k) % 8], w);
    end
    wr(6'h01, 8'h50);
    rdchk(6'h01, 8'h50);
    clkchk(8, 4);
    stop_test;
  end
endmodule // scftp_top_tb
